// *** swc_params.svh ***
// offsets, field positions, reset values and timing counts for the sleep/wake controller
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH
`define SWC_OFF_PIN_CHANGE_ENABLE_MASK 12'h000
`define SWC_OFF_INTERRUPT_CONTROL_MAIN 12'h004
`define SWC_OFF_PERIPHERAL_IRQ_ENABLE_1 12'h008
`define SWC_OFF_PERIPHERAL_IRQ_ENABLE_2 12'h00C
`define SWC_OFF_PERIPHERAL_IRQ_FLAGS_1 12'h010
`define SWC_OFF_PERIPHERAL_IRQ_FLAGS_2 12'h014
`define SWC_OFF_STATUS 12'h018
`define SWC_OFF_WAKE_QUALIFY 12'h01C
`define SWC_REG_RESET 8'h00
`define SWC_INTERRUPT_CONTROL_MAIN_GIE 7
`define SWC_INTERRUPT_CONTROL_MAIN_PERIPHERAL_IRQ_GLOBAL_ENABLE 6
`define SWC_INTERRUPT_CONTROL_MAIN_T0IE 5
`define SWC_INTERRUPT_CONTROL_MAIN_INTE 4
`define SWC_INTERRUPT_CONTROL_MAIN_RBIE 3
`define SWC_INTERRUPT_CONTROL_MAIN_T0IF 2
`define SWC_INTERRUPT_CONTROL_MAIN_INTF 1
`define SWC_INTERRUPT_CONTROL_MAIN_RBIF 0
`define SWC_P1_ADC 6
`define SWC_P1_RX 5
`define SWC_P1_CAP1 2
`define SWC_P1_T1 0
`define SWC_P2_CAP2 0
`define SWC_P2_MASK 8'h01
`define SWC_Q_T1ASYNC 0
`define SWC_Q_RXSLAVE 1
`define SWC_Q_ADCRC 2
`define SWC_Q_WDTEN 3
`define SWC_ST_TO 0
`define SWC_ST_PD 1
`define SWC_ST_SLEEP 2
`define SWC_IRQ_VECTOR 13'h0004
`define SWC_OSC_RESTART_CYCLES 4
`endif

// *** swc_pkg.sv ***
// types for the sleep/wake controller
package swc_pkg;
  typedef enum logic [3:0] {
    SWC_RUN = 4'b0001,
    SWC_ENTER = 4'b0010,
    SWC_SLEEP = 4'b0100,
    SWC_WAKE = 4'b1000
  } swc_state_e;
endpackage

// *** swc_sleep_wake_controller.sv ***
// sleep and wake-up controller with apb register file
// Operation
// [R1] sleep instruction enters power-down
// [R2] sleep clears watchdog, keeps it running
// [R3] sleep clears powerdown flag, sets timeout flag
// [R4] main oscillator off, timer-one oscillator untouched
// [R5] ports hold their drive during sleep
// [R6] watchdog reset never drives reset pin
// [R7] pin reset resets, others resume
// [R8] powerdown set at power-up; watchdog wake clears timeout
// [R9] only listed peripherals may wake
// [R10] other peripherals raise nothing in sleep
// [R11] next instruction prefetched during sleep
// [R12] wake needs own enable, ignores global
// [R13] global enable set vectors after next instruction
// [R14] pending enabled flag wakes immediately; the code masks the T0IE/T0IF pair while asleep, so it never wakes
// [R15] every wake clears the watchdog
// [R16] pending before sleep makes it a no-op
// [R17] flag during sleep completes sleep then wakes
// [R18] powerdown still set means sleep was no-op
// [R19] second enable/flag registers implement bit 0
// [R20] wake request is or of flag-and-enable; the code leaves the T0IE/T0IF pair out while asleep
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "swc_params.svh"
module swc_sleep_wake_controller
  import swc_pkg::*;
#(
  parameter int OSC_RESTART = `SWC_OSC_RESTART_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core sequencer
  input wire logic sleepExec,
  input wire logic watchdogClearOp,
  output logic coreHalt,
  output logic prefetchNext,
  output logic vectorIrq,
  output logic resumeExec,
  // oscillator and port hold
  output logic mainOscEnable,
  output logic portHold,
  // watchdog
  input wire logic watchdogTimeout,
  output logic watchdogClear,
  output logic deviceReset,
  output logic externalResetPinDrive,
  // raw interrupt events from peripherals and pins
  input wire logic externalResetPin,
  input wire logic [7:0] portbChange,
  input wire logic externalIrqPin,
  input wire logic [7:0] periphEvent1,
  input wire logic periphEvent2
);

  swc_state_e state;
  logic [7:0] pinChangeEnableMask;
  logic [7:0] interruptControlMain;
  logic [7:0] peripheralIrqEnable1;
  logic [7:0] peripheralIrqEnable2;
  logic [7:0] peripheralIrqFlags1;
  logic [7:0] peripheralIrqFlags2;
  logic [7:0] wakeQualify;
  logic powerdownFlagN;
  logic timeoutFlagN;
  logic [2:0] oscCount;
  logic rstPinMeta, rstPinSync;
  logic intPinMeta, intPinSync, intPinPrev;
  logic [7:0] pbMeta, pbSync, pbPrev;
  logic wdtMeta, wdtSync;
  logic busWrite, busRead;
  logic [31:0] next_prdata;
  logic asleep, pendingWake, periphAny, wakeWatchdog;
  logic [7:0] p1Allowed;
  logic wrIntcon, wrFlags1, wrFlags2;

  // two-stage synchronisers for pin inputs
  always_ff @(posedge clk)
  begin
    rstPinMeta <= externalResetPin;
    rstPinSync <= rstPinMeta;
    intPinMeta <= externalIrqPin;
    intPinSync <= intPinMeta;
    intPinPrev <= intPinSync;
    pbMeta <= portbChange;
    pbSync <= pbMeta;
    pbPrev <= pbSync;
    wdtMeta <= watchdogTimeout;
    wdtSync <= wdtMeta;
  end

  // bus strobes, zero wait states
  assign busWrite = psel & penable & pwrite;
  assign busRead = psel & ~penable & ~pwrite;
  assign asleep = (state == SWC_SLEEP);
  assign wrIntcon = busWrite && paddr == `SWC_OFF_INTERRUPT_CONTROL_MAIN;
  assign wrFlags1 = busWrite && paddr == `SWC_OFF_PERIPHERAL_IRQ_FLAGS_1;
  assign wrFlags2 = busWrite && paddr == `SWC_OFF_PERIPHERAL_IRQ_FLAGS_2;

  // asleep only the wake-capable peripherals may flag
  always_comb
  begin
    p1Allowed = 8'hFF;
    if (asleep)
    begin
      p1Allowed = 8'h00; // see [R10]
      p1Allowed[`SWC_P1_T1] = wakeQualify[`SWC_Q_T1ASYNC]; // see [R9]
      p1Allowed[`SWC_P1_RX] = wakeQualify[`SWC_Q_RXSLAVE];
      p1Allowed[`SWC_P1_ADC] = wakeQualify[`SWC_Q_ADCRC];
      p1Allowed[`SWC_P1_CAP1] = 1'b1;
    end
  end

  // wake request from flag-and-enable pairs, global enable ignored
  assign periphAny = |(peripheralIrqFlags1 & peripheralIrqEnable1)
    | |(peripheralIrqFlags2 & peripheralIrqEnable2 & `SWC_P2_MASK);
  assign pendingWake = periphAny // see [R20] [R12]
    | (interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_INTE] & interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_INTF])
    | (interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_RBIE] & interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_RBIF])
    | (interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_T0IE] & interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_T0IF] & ~asleep);
  assign wakeWatchdog = asleep & wdtSync & wakeQualify[`SWC_Q_WDTEN];

  // software-writable control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinChangeEnableMask <= `SWC_REG_RESET;
      peripheralIrqEnable1 <= `SWC_REG_RESET;
      peripheralIrqEnable2 <= `SWC_REG_RESET;
      wakeQualify <= `SWC_REG_RESET;
    end
    else if (busWrite)
    begin
      case (paddr)
        `SWC_OFF_PIN_CHANGE_ENABLE_MASK: pinChangeEnableMask <= pwdata[7:0];
        `SWC_OFF_PERIPHERAL_IRQ_ENABLE_1: peripheralIrqEnable1 <= pwdata[7:0];
        `SWC_OFF_PERIPHERAL_IRQ_ENABLE_2: peripheralIrqEnable2 <= pwdata[7:0] & `SWC_P2_MASK; // see [R19]
        `SWC_OFF_WAKE_QUALIFY: wakeQualify <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // interrupt control and flags, hardware set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      interruptControlMain <= `SWC_REG_RESET;
      peripheralIrqFlags1 <= `SWC_REG_RESET;
      peripheralIrqFlags2 <= `SWC_REG_RESET;
    end
    else
    begin
      if (wrIntcon)
        interruptControlMain <= pwdata[7:0];
      if (intPinSync & ~intPinPrev)
        interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_INTF] <= 1'b1;
      if (|((pbSync ^ pbPrev) & pinChangeEnableMask))
        interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_RBIF] <= 1'b1;
      peripheralIrqFlags1 <= (wrFlags1 ? pwdata[7:0] : peripheralIrqFlags1)
        | (periphEvent1 & p1Allowed);
      peripheralIrqFlags2 <= ((wrFlags2 ? pwdata[7:0] : peripheralIrqFlags2)
        | {7'd0, periphEvent2}) & `SWC_P2_MASK; // see [R19]
    end
  end

  // sleep sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= SWC_RUN;
      oscCount <= 3'd0;
      vectorIrq <= 1'b0;
      resumeExec <= 1'b0;
    end
    else
    begin
      vectorIrq <= 1'b0;
      resumeExec <= 1'b0;
      case (state)
        SWC_RUN:
          if (sleepExec && !pendingWake) // see [R1] [R16]
            state <= SWC_ENTER;
        SWC_ENTER:
          state <= SWC_SLEEP; // see [R17] sleep completes before wake
        SWC_SLEEP:
          if (pendingWake || wakeWatchdog) // see [R14] [R7]
          begin
            state <= SWC_WAKE;
            oscCount <= OSC_RESTART[2:0];
          end
        SWC_WAKE:
          if (oscCount == 3'd0)
          begin
            state <= SWC_RUN;
            resumeExec <= 1'b1;
            vectorIrq <= interruptControlMain[`SWC_INTERRUPT_CONTROL_MAIN_GIE] & pendingWake; // see [R13]
          end
          else
            oscCount <= oscCount - 3'd1;
        default: state <= SWC_RUN;
      endcase
    end
  end

  // status flags: power-down and time-out, active low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      powerdownFlagN <= 1'b1; // see [R8]
      timeoutFlagN <= 1'b1;
    end
    else if (state == SWC_RUN && sleepExec && !pendingWake)
    begin
      powerdownFlagN <= 1'b0; // see [R3] [R18]
      timeoutFlagN <= 1'b1;
    end
    else if (watchdogClearOp)
    begin
      powerdownFlagN <= 1'b1;
      timeoutFlagN <= 1'b1;
    end
    else if (wakeWatchdog && !pendingWake)
      timeoutFlagN <= 1'b0; // see [R8]
  end

  // registered control outputs to core, oscillator and watchdog
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coreHalt <= 1'b0;
      prefetchNext <= 1'b0;
      mainOscEnable <= 1'b1;
      portHold <= 1'b0;
      watchdogClear <= 1'b0;
      deviceReset <= 1'b0;
      externalResetPinDrive <= 1'b0;
    end
    else
    begin
      coreHalt <= (state != SWC_RUN) || (sleepExec && !pendingWake);
      prefetchNext <= (state == SWC_RUN) && sleepExec; // see [R11]
      mainOscEnable <= !(state == SWC_SLEEP); // see [R4]
      portHold <= (state == SWC_ENTER) || (state == SWC_SLEEP); // see [R5]
      watchdogClear <= watchdogClearOp || (state == SWC_RUN && sleepExec && !pendingWake) // see [R2]
        || (state == SWC_SLEEP && (pendingWake || wakeWatchdog)); // see [R15]
      deviceReset <= rstPinSync; // see [R7]
      externalResetPinDrive <= 1'b0; // see [R6]
    end
  end

  // read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `SWC_OFF_PIN_CHANGE_ENABLE_MASK: next_prdata[7:0] = pinChangeEnableMask;
      `SWC_OFF_INTERRUPT_CONTROL_MAIN: next_prdata[7:0] = interruptControlMain;
      `SWC_OFF_PERIPHERAL_IRQ_ENABLE_1: next_prdata[7:0] = peripheralIrqEnable1;
      `SWC_OFF_PERIPHERAL_IRQ_ENABLE_2: next_prdata[7:0] = peripheralIrqEnable2;
      `SWC_OFF_PERIPHERAL_IRQ_FLAGS_1: next_prdata[7:0] = peripheralIrqFlags1;
      `SWC_OFF_PERIPHERAL_IRQ_FLAGS_2: next_prdata[7:0] = peripheralIrqFlags2;
      `SWC_OFF_STATUS: next_prdata[2:0] = {asleep, powerdownFlagN, timeoutFlagN};
      `SWC_OFF_WAKE_QUALIFY: next_prdata[7:0] = wakeQualify;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // apb answer registered in setup phase, ready in access
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (busRead)
        prdata <= next_prdata;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `SWC_OFF_WAKE_QUALIFY || paddr[1:0] != 2'b00);
    end
  end

  // sleep entry clears the powerdown flag
  sleep_flags_a: assert property (@(posedge clk) disable iff (rst) // see [R3]
    (state == SWC_RUN && sleepExec && !pendingWake) |=> (!powerdownFlagN && timeoutFlagN))
    else $error("sleep entry did not update status flags");

  // pending wake turns sleep into a no-op
  sleep_noop_a: assert property (@(posedge clk) disable iff (rst) // see [R16]
    (state == SWC_RUN && sleepExec && pendingWake && !watchdogClearOp) |=> ($stable(powerdownFlagN) && state == SWC_RUN))
    else $error("sleep with pending wake was not a no-op");

  // oscillator off while sleeping
  osc_off_a: assert property (@(posedge clk) disable iff (rst) // see [R4]
    (state == SWC_SLEEP) |=> !mainOscEnable)
    else $error("oscillator still enabled in sleep");

  // sleep entry goes on into sleep the next cycle
  sequence enterSeq;
    state == SWC_ENTER ##1 state == SWC_SLEEP;
  endsequence
  sleep_complete_a: assert property (@(posedge clk) disable iff (rst) // see [R17]
    (state == SWC_ENTER) |-> enterSeq)
    else $error("sleep entry did not complete");

  // wake clears watchdog next cycle
  wake_clear_a: assert property (@(posedge clk) disable iff (rst) // see [R15]
    (state == SWC_SLEEP && (pendingWake || wakeWatchdog)) |=> watchdogClear ##0 state == SWC_WAKE)
    else $error("wake did not clear watchdog");

  // resume after oscillator restart
  resume_time_a: assert property (@(posedge clk) disable iff (rst) // see [R7]
    (state == SWC_SLEEP ##1 state == SWC_WAKE) |-> ##[1:8] resumeExec)
    else $error("no resume after wake");

  // reset pin never driven
  pin_drive_a: assert property (@(posedge clk) disable iff (rst) // see [R6]
    !externalResetPinDrive)
    else $error("reset pin driven");

  // second flag register keeps only bit 0
  flags2_bits_a: assert property (@(posedge clk) disable iff (rst) // see [R19]
    peripheralIrqFlags2[7:1] == 7'd0 && peripheralIrqEnable2[7:1] == 7'd0)
    else $error("unimplemented bits set");

  // prefetch pulses with sleep instruction
  prefetch_next_a: assert property (@(posedge clk) disable iff (rst) // see [R11]
    (state == SWC_RUN && sleepExec) |=> prefetchNext)
    else $error("no prefetch on sleep");

  // core stays halted while not running
  core_halt_a: assert property (@(posedge clk) disable iff (rst) // see [R1]
    (state != SWC_RUN) |=> coreHalt)
    else $error("core not halted outside run");

  // ports frozen while asleep
  port_hold_a: assert property (@(posedge clk) disable iff (rst) // see [R5]
    (state == SWC_SLEEP) |=> portHold)
    else $error("ports not held in sleep");

  // watchdog wake clears the timeout flag
  wdt_timeout_a: assert property (@(posedge clk) disable iff (rst) // see [R8]
    (wakeWatchdog && !pendingWake && !watchdogClearOp) |=> !timeoutFlagN)
    else $error("watchdog wake kept timeout flag");

  // pin reset reaches the device reset output
  pin_reset_a: assert property (@(posedge clk) disable iff (rst) // see [R7]
    rstPinSync |=> deviceReset)
    else $error("pin reset not passed on");

  // no-op sleep leaves the watchdog alone
  noop_watchdog_a: assert property (@(posedge clk) disable iff (rst) // see [R16]
    (state == SWC_RUN && sleepExec && pendingWake && !watchdogClearOp) |=> !watchdogClear)
    else $error("no-op sleep cleared watchdog");

  // vector only together with resume
  vector_resume_a: assert property (@(posedge clk) disable iff (rst) // see [R13]
    vectorIrq |-> resumeExec)
    else $error("vector without resume");

endmodule
`default_nettype wire

// *** swc_core_model.sv ***
// core sequencer model: issues sleep and counts the controller's pulses
`timescale 1ns/10ps
`default_nettype none
module swc_core_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench request
  input wire logic sleepReq,
  // controller outputs watched
  input wire logic coreHalt,
  input wire logic prefetchNext,
  input wire logic resumeExec,
  input wire logic vectorIrq,
  input wire logic watchdogClear,
  // to controller and bench
  output logic sleepExec,
  output int nResume,
  output int nVector,
  output int nWdClr,
  output int nPrefetch
);
  // one-cycle sleep pulse, only while the core is running
  always_ff @(posedge clk)
  begin
    if (rst)
      sleepExec <= 1'b0;
    else
      sleepExec <= sleepReq && !coreHalt && !sleepExec;
  end
  // pulse counters for the bench
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nResume <= 0;
      nVector <= 0;
      nWdClr <= 0;
      nPrefetch <= 0;
    end
    else
    begin
      nResume <= nResume + int'(resumeExec);
      nVector <= nVector + int'(vectorIrq);
      nWdClr <= nWdClr + int'(watchdogClear);
      nPrefetch <= nPrefetch + int'(prefetchNext);
    end
  end
endmodule
`default_nettype wire

// *** tb_sleep_wake_controller.sv ***
// self-checking bench for the sleep/wake controller
`timescale 1ns/10ps
`default_nettype none
`include "swc_params.svh"
module tb_sleep_wake_controller;
  localparam int OSC = 2;
  localparam int BITS[6] = '{1, 0, 5, 6, 2, 8};
  localparam int QUAL[6] = '{0, 1, 2, 4, 0, 0};
  localparam int WAKES[6] = '{0, 1, 1, 1, 1, 1};
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleepReq = 0;
  logic wdTo = 0, extRst = 0, extIrq = 0, wdOp = 0, pev2 = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] pbc = 0, pev1 = 0;
  logic pready, pslverr, sleepExec, coreHalt, prefetchNext, vectorIrq, resumeExec;
  logic mainOscEnable, portHold, watchdogClear, deviceReset, extDrive;
  int nResume, nVector, nWdClr, nPrefetch, r, v, w, p, cyc = 0;
  int num_errors = 0, n_compared = 0;
  // clock
  always #5 clk = ~clk;
  swc_sleep_wake_controller #(.OSC_RESTART(OSC)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepExec(sleepExec), .watchdogClearOp(wdOp), .coreHalt(coreHalt), .prefetchNext(prefetchNext),
    .vectorIrq(vectorIrq), .resumeExec(resumeExec), .mainOscEnable(mainOscEnable), .portHold(portHold),
    .watchdogTimeout(wdTo), .watchdogClear(watchdogClear), .deviceReset(deviceReset),
    .externalResetPinDrive(extDrive), .externalResetPin(extRst), .portbChange(pbc),
    .externalIrqPin(extIrq), .periphEvent1(pev1), .periphEvent2(pev2));
  swc_core_model core (.clk(clk), .rst(rst), .sleepReq(sleepReq), .coreHalt(coreHalt),
    .prefetchNext(prefetchNext), .resumeExec(resumeExec), .vectorIrq(vectorIrq),
    .watchdogClear(watchdogClear), .sleepExec(sleepExec), .nResume(nResume), .nVector(nVector),
    .nWdClr(nWdClr), .nPrefetch(nPrefetch));
  // verdict
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdChk(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  task snap;
    r = nResume;
    v = nVector;
    w = nWdClr;
    p = nPrefetch;
  endtask
  task goSleep;
    snap();
    @(posedge clk);
    sleepReq <= 1'b1;
    @(posedge clk);
    sleepReq <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  // reset values, unimplemented bits, unmapped offset
  task t_regs;
    rdChk(`SWC_OFF_STATUS, 8'h03, "status at power-up");
    for (int i = 0; i < 6; i++)
      rdChk(12'(4 * i), 8'h00, "register reset");
    apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_ENABLE_2, 8'hFF);
    rdChk(`SWC_OFF_PERIPHERAL_IRQ_ENABLE_2, 8'h01, "enable2 bits");
    apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_ENABLE_2, 8'h00);
    apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_FLAGS_2, 8'hFF);
    rdChk(`SWC_OFF_PERIPHERAL_IRQ_FLAGS_2, 8'h01, "flags2 bits");
    apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_FLAGS_2, 8'h00);
    apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_ENABLE_1, 8'hA4);
    rdChk(`SWC_OFF_PERIPHERAL_IRQ_ENABLE_1, 8'hA4, "enable1 rw");
    apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_ENABLE_1, 8'h00);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 8'h00, "unmapped data");
  endtask
  // enabled flag pending before sleep: sleep is a no-op
  task t_noop;
    apb(1'b1, `SWC_OFF_INTERRUPT_CONTROL_MAIN, 8'h12);
    goSleep();
    chk(coreHalt, 1'b0, "no-op halted");
    chk(nWdClr, w, "no-op watchdog clear");
    rdChk(`SWC_OFF_STATUS, 8'h03, "no-op flags");
    apb(1'b1, `SWC_OFF_INTERRUPT_CONTROL_MAIN, 8'h00);
  endtask
  // pin or port-change wake, global enable off or on
  task t_irq(input logic global_irq_enable, input logic portb);
    apb(1'b1, `SWC_OFF_PIN_CHANGE_ENABLE_MASK, 8'h01);
    apb(1'b1, `SWC_OFF_INTERRUPT_CONTROL_MAIN, {global_irq_enable, 2'b00, !portb, portb, 3'b000});
    goSleep();
    chk(coreHalt, 1'b1, "halted");
    chk(portHold, 1'b1, "ports held");
    chk(mainOscEnable, 1'b0, "oscillator off");
    chk(nPrefetch, p + 1, "prefetch");
    chk(nWdClr, w + 1, "sleep watchdog clear");
    rdChk(`SWC_OFF_STATUS, 8'h05, "sleep flags");
    @(posedge clk);
    pbc <= {7'h00, portb};
    extIrq <= !portb;
    repeat (20) @(posedge clk);
    chk(nResume, r + 1, "irq wake");
    chk(nVector, v + int'(global_irq_enable), "vector");
    chk(nWdClr, w + 2, "wake watchdog clear");
    chk(mainOscEnable, 1'b1, "oscillator back");
    extIrq <= 1'b0;
    pbc <= 8'h00;
    repeat (4) @(posedge clk);
    apb(1'b1, `SWC_OFF_INTERRUPT_CONTROL_MAIN, 8'h00);
    apb(1'b1, `SWC_OFF_PIN_CHANGE_ENABLE_MASK, 8'h00);
  endtask
  // watchdog wake, then the clear op restores both flags
  task t_wdt;
    apb(1'b1, `SWC_OFF_WAKE_QUALIFY, 8'h08);
    goSleep();
    wdTo <= 1'b1;
    repeat (20) @(posedge clk);
    chk(nResume, r + 1, "watchdog wake");
    chk(nVector, v, "watchdog no vector");
    chk(extDrive, 1'b0, "reset pin not driven");
    rdChk(`SWC_OFF_STATUS, 8'h00, "watchdog wake flags");
    wdTo <= 1'b0;
    wdOp <= 1'b1;
    @(posedge clk);
    wdOp <= 1'b0;
    rdChk(`SWC_OFF_STATUS, 8'h03, "clear op flags");
    apb(1'b1, `SWC_OFF_WAKE_QUALIFY, 8'h00);
  endtask
  // peripheral sources: one unable to wake, then each able one
  task t_periph;
    apb(1'b1, `SWC_OFF_INTERRUPT_CONTROL_MAIN, 8'h40);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_FLAGS_1, 8'h00);
      apb(1'b1, `SWC_OFF_WAKE_QUALIFY, 32'(QUAL[i]));
      apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_ENABLE_1, 32'((1 << BITS[i]) & 255));
      apb(1'b1, `SWC_OFF_PERIPHERAL_IRQ_ENABLE_2, 32'(BITS[i] == 8));
      goSleep();
      pev1 <= 8'((1 << BITS[i]) & 255);
      pev2 <= BITS[i] == 8;
      @(posedge clk);
      pev1 <= 8'h00;
      pev2 <= 1'b0;
      repeat (20) @(posedge clk);
      chk(nResume, r + WAKES[i], "peripheral wake");
    end
    for (int i = 1; i < 6; i++)
      apb(1'b1, 12'(4 * i), 8'h00);
  endtask
  // reset pin during sleep: device reset, no resume
  task t_pin;
    goSleep();
    extRst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(deviceReset, 1'b1, "pin reset");
    chk(nResume, r, "pin no resume");
    chk(extDrive, 1'b0, "pin not driven");
    extRst <= 1'b0;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_noop();
    t_irq(1'b0, 1'b0);
    t_irq(1'b1, 1'b1);
    t_wdt();
    t_periph();
    t_pin();
    tally_and_finish();
  end
endmodule
`default_nettype wire
